// >>> hdl/csr_pkg.sv
`default_nettype none
package csr_pkg;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int FRAME_BITS  = 32;
	localparam int HDR_BITS    = 12;
	localparam int ADDR_BITS   = 4;
	localparam int DATA_BITS   = 16;
	localparam logic [11:0] HDR_PATTERN = 12'h001;
	localparam int CAL_BIT     = 15;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [3:0] ADDR_CAL        = 4'h0;
	localparam logic [3:0] ADDR_CONFIG     = 4'h1;
	localparam logic [3:0] ADDR_CH1_OFFSET = 4'h2;
	localparam logic [3:0] ADDR_CH1_FS     = 4'h3;
	localparam logic [3:0] ADDR_EXT_CONFIG = 4'h9;
	localparam logic [3:0] ADDR_CH2_OFFSET = 4'hA;
	localparam logic [3:0] ADDR_CH2_FS     = 4'hB;
	localparam logic [3:0] ADDR_PHASE_FINE = 4'hE;
	localparam logic [3:0] ADDR_PHASE_CRS  = 4'hF;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_CAL     = 16'h7FFF;
	localparam logic [15:0] RST_CONFIG  = 16'hB2FF;
	localparam logic [15:0] RST_OTHER   = 16'h0000;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] data;
	} csr_frame_t;

	typedef struct packed {
		logic [15:0] config_w;
		logic [15:0] ch1_offset;
		logic [15:0] ch1_fullscale;
		logic [15:0] ext_config;
		logic [15:0] ch2_offset;
		logic [15:0] ch2_fullscale;
		logic [15:0] phase_fine;
		logic [15:0] phase_coarse;
	} csr_regs_t;

endpackage
`default_nettype wire

// >>> hdl/csr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module csr_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic d,
	output logic      q
);
	logic meta_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/csr_shift.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Serial frame receiver on the link clock
// ****************************************
module csr_shift
	import csr_pkg::*;
(
	input  wire logic          sclk,
	input  wire logic          rst,
	input  wire logic          serial_select_n,
	input  wire logic          serial_input_line,
	output csr_pkg::csr_frame_t frame_r,
	output logic               frame_tgl_r
);
	logic [30:0] shreg_r;
	logic [4:0]  count_r;
	logic [31:0] word;

	assign word = {shreg_r, serial_input_line};

	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			shreg_r <= '0;
		end else if (!serial_select_n) begin
			shreg_r <= word[30:0];
		end
	end

	// Select high clears the count at once, since sclk may stop right after a cut frame
	always_ff @(posedge sclk or posedge rst or posedge serial_select_n) begin
		if (rst || serial_select_n) begin
			count_r <= '0;
		end else begin
			count_r <= count_r + 5'h01;
		end
	end

	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			frame_r     <= '0;
			frame_tgl_r <= 1'b0;
		end else if (!serial_select_n && count_r == 5'(FRAME_BITS - 1)
				&& word[31 -: HDR_BITS] == HDR_PATTERN) begin
			frame_r.addr <= word[DATA_BITS +: ADDR_BITS];
			frame_r.data <= word[DATA_BITS-1:0];
			frame_tgl_r  <= ~frame_tgl_r;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/csr_bank.sv
`timescale 1ns/1ps
`default_nettype none
module csr_bank
	import csr_pkg::*;
(
	input  wire logic          core_clk,
	input  wire logic          rst,
	input  wire logic          sclk,
	input  wire logic          serial_select_n,
	input  wire logic          serial_input_line,
	input  wire logic          extended_mode,
	input  wire logic          cal_pin,
	output csr_pkg::csr_regs_t regs_out,
	output logic               cal_start,
	output logic               cal_busy_seen
);
	import csr_pkg::*;

	csr_frame_t frame_sclk;
	logic       tgl_sclk;
	logic       tgl_sync;
	logic       tgl_seen_r;
	logic       ext_sync;
	logic       pin_sync;
	logic       pin_prev_r;
	logic       write_stb;
	logic       cal_reg_bit_r;
	logic       busy_r;
	csr_regs_t  regs_r;

	// ****************************************
	// Link capture and crossing
	// ****************************************
	csr_shift u_shift (
		.sclk              (sclk),
		.rst               (rst),
		.serial_select_n   (serial_select_n),
		.serial_input_line (serial_input_line),
		.frame_r           (frame_sclk),
		.frame_tgl_r       (tgl_sclk)
	);

	csr_sync u_sync_tgl (.clk(core_clk), .rst(rst), .d(tgl_sclk), .q(tgl_sync));
	csr_sync u_sync_ext (.clk(core_clk), .rst(rst), .d(extended_mode), .q(ext_sync));
	csr_sync u_sync_pin (.clk(core_clk), .rst(rst), .d(cal_pin), .q(pin_sync));

	// Frame word stays stable for a whole frame time after the toggle, so capture is safe
	assign write_stb = tgl_sync ^ tgl_seen_r;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tgl_seen_r <= 1'b0;
		end else begin
			tgl_seen_r <= tgl_sync;
		end
	end

	// ****************************************
	// Register file, write only
	// ****************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regs_r        <= '0;
			regs_r.config_w <= RST_CONFIG;
			cal_reg_bit_r <= RST_CAL[CAL_BIT];
		end else begin
			cal_reg_bit_r <= 1'b0;
			if (write_stb && ext_sync) begin
				unique case (frame_sclk.addr)
				ADDR_CAL:        cal_reg_bit_r        <= frame_sclk.data[CAL_BIT];
				ADDR_CONFIG:     regs_r.config_w      <= frame_sclk.data;
				ADDR_CH1_OFFSET: regs_r.ch1_offset    <= frame_sclk.data;
				ADDR_CH1_FS:     regs_r.ch1_fullscale <= frame_sclk.data;
				ADDR_EXT_CONFIG: regs_r.ext_config    <= frame_sclk.data;
				ADDR_CH2_OFFSET: regs_r.ch2_offset    <= frame_sclk.data;
				ADDR_CH2_FS:     regs_r.ch2_fullscale <= frame_sclk.data;
				ADDR_PHASE_FINE: regs_r.phase_fine    <= frame_sclk.data;
				ADDR_PHASE_CRS:  regs_r.phase_coarse  <= frame_sclk.data;
				default: ;
				endcase
			end
		end
	end

	// Outside extended mode the core sees power-on values only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regs_out <= '0;
			regs_out.config_w <= RST_CONFIG;
		end else if (ext_sync) begin
			regs_out <= regs_r;
		end else begin
			regs_out <= '0;
			regs_out.config_w <= RST_CONFIG;
		end
	end

	// ****************************************
	// Shared calibration trigger
	// ****************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_prev_r <= 1'b0;
			cal_start  <= 1'b0;
			busy_r     <= 1'b0;
		end else begin
			pin_prev_r <= pin_sync;
			cal_start  <= cal_reg_bit_r || (pin_sync && !pin_prev_r);
			// Flags a write arriving right after a calibration request
			busy_r     <= write_stb && (cal_start || cal_reg_bit_r);
		end
	end

	assign cal_busy_seen = busy_r;
endmodule
`default_nettype wire

// >>> tb/csr_bank_checker.sv
`timescale 1ns/1ps
`default_nettype none
module csr_bank_checker
	import csr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic serial_select_n,
	input wire logic serial_input_line,
	input wire logic extended_mode,
	input wire logic cal_pin,
	input wire csr_pkg::csr_regs_t regs_out,
	input wire logic cal_start,
	input wire logic cal_busy_seen
);
	import csr_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	cal_pulse_a: assert property (cal_start |=> !cal_start) else $error("cal long");
	pin_cal_a: assert property ($rose(cal_pin) |-> ##[2:6] cal_start) else $error("pin");
	normal_def_a: assert property (!extended_mode [*6] |-> regs_out == {RST_CONFIG, 112'h0})
		else $error("normal regs");
	mode_off_a: assert property ($fell(extended_mode) |-> ##[1:5] regs_out.phase_fine == 0)
		else $error("mode off");
	reset_def_a: assert property ($fell(rst) |-> regs_out.config_w == RST_CONFIG && !cal_start)
		else $error("reset");
	idle_hold_a: assert property ((serial_select_n && extended_mode) [*8] |-> $stable(regs_out))
		else $error("regs moved");
	cal_cause_a: assert property ((serial_select_n && !cal_pin) [*8] |-> !cal_start)
		else $error("stray cal");
	normal_cal_a: assert property ((!extended_mode && !cal_pin) [*8] |-> !cal_start)
		else $error("normal cal");
	cover property (cal_start);
	cover property ($fell(extended_mode));
	cover property (cal_busy_seen);
endmodule
`default_nettype wire

// >>> tb/csr_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module csr_ctl_model (
	output logic sclk,
	output logic serial_select_n,
	output logic serial_input_line
);
	initial begin
		sclk = 0;
		serial_select_n = 1;
		serial_input_line = 0;
	end
	// Clock stands still between frames; offset keeps it off the core clock phase
	task automatic frame(input logic [31:0] w, input bit keep);
		if (serial_select_n) #3;
		for (int i = 31; i >= 0; i--) begin
			serial_select_n = 0;
			serial_input_line = w[i];
			#32 sclk = 1;
			#32 sclk = 0;
		end
		if (!keep) begin
			#16 serial_select_n = 1;
			serial_input_line = ~serial_input_line;
		end
	endtask
endmodule
`default_nettype wire

// >>> tb/csr_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module csr_bank_bench;
	import csr_pkg::*;
	logic core_clk = 0, rst = 1, extended_mode = 1, cal_pin = 0;
	logic sclk, serial_select_n, serial_input_line, cal_start, cal_busy_seen;
	csr_regs_t regs_out, exp_r;
	int n_errors = 0, comparisons = 0, seen, busy;
	csr_bank csr_bank_inst (.*);
	csr_ctl_model csr_ctl_model_inst (.*);
	initial forever #4 core_clk = ~core_clk;
	task automatic check(string what, logic [127:0] got, logic [127:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d, bit keep);
		csr_ctl_model_inst.frame({HDR_PATTERN, a, d}, keep);
	endtask
	task automatic count_cal(int n);
		seen = 0;
		busy = 0;
		repeat (n) begin
			@(negedge core_clk);
			seen += (cal_start === 1'b1);
			busy += (cal_busy_seen === 1'b1);
		end
	endtask
	task automatic t_all;
		logic [3:0] a [8] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF};
		wr(ADDR_CAL, RST_CAL, 1);
		for (int i = 0; i < 8; i++) begin
			wr(a[i], {a[i], 12'hC35}, 1);
			exp_r[127 - 16 * i -: 16] = {a[i], 12'hC35};
		end
		for (int r = 4; r < 14; r++)
			if (r < 9 || r > 11) wr(r[3:0], 16'hDEAD, 1);
		csr_ctl_model_inst.frame({12'h002, ADDR_CH1_OFFSET, 16'hBEEF}, 0);
		repeat (10) @(negedge core_clk);
		check("all regs", regs_out, exp_r);
		$display("t_all done");
	endtask
	task automatic t_cal;
		fork
			wr(ADDR_CAL, 16'hFFFF, 0);
			count_cal(300);
		join
		check("cal bit", seen, 1);
		check("busy flag", busy, 0);
		repeat (200) @(negedge core_clk);
		fork
			wr(ADDR_CAL, RST_CAL, 0);
			count_cal(300);
		join
		check("cal idle", seen, 0);
		cal_pin = 1;
		count_cal(20);
		cal_pin = 0;
		check("cal pin", seen, 1);
		check("pin busy", busy, 0);
		$display("t_cal done");
	endtask
	task automatic t_normal;
		@(negedge core_clk) extended_mode = 0;
		repeat (6) @(negedge core_clk);
		check("normal regs", regs_out, {RST_CONFIG, 112'h0});
		wr(ADDR_CH1_FS, 16'h0BAD, 0);
		fork
			wr(ADDR_CAL, 16'hFFFF, 0);
			count_cal(300);
		join
		check("normal cal", seen, 0);
		@(negedge core_clk) extended_mode = 1;
		repeat (8) @(negedge core_clk);
		check("kept regs", regs_out, exp_r);
		$display("t_normal done");
	endtask
	initial begin
		repeat (5) @(negedge core_clk);
		rst = 0;
		repeat (3) @(negedge core_clk);
		check("reset regs", regs_out, {RST_CONFIG, 112'h0});
		$display("t_reset done");
		t_all;
		t_cal;
		t_normal;
		end_sim;
	end
endmodule
bind csr_bank csr_bank_checker csr_bank_checker_inst (.*);
`default_nettype wire
